// >>> verilog/pepsp_pkg.sv
// Package holding the register map, resets, pin roles and state types of the port block.
`default_nettype none
package pepsp_pkg;

  localparam int unsigned ADDR_W   = 5;
  localparam int unsigned DATA_W   = 32;

  // Register byte offsets.
  localparam logic [4:0] OFF_PIN_DATA = 5'h00;
  localparam logic [4:0] OFF_OUT_LAT  = 5'h04;
  localparam logic [4:0] OFF_DIR_CTL  = 5'h08;
  localparam logic [4:0] OFF_BYTE_DAT = 5'h0C;
  localparam logic [4:0] OFF_ANA_CFG  = 5'h10;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h14;

  // Field positions in the direction and slave control register and in the interrupt status register.
  localparam int unsigned CTL_IBF_BIT  = 7;
  localparam int unsigned CTL_OBF_BIT  = 6;
  localparam int unsigned CTL_INPUT_OVERRUN_BIT = 5;
  localparam int unsigned CTL_MODE_BIT = 4;
  localparam int unsigned IRQ_FLAG_BIT = 0;

  // Roles of the three pins in slave port mode.
  localparam int unsigned PIN_RD = 0;
  localparam int unsigned PIN_WR = 1;
  localparam int unsigned PIN_CS = 2;

  // Values after reset, and the analog setting value for all pins digital.
  localparam logic [2:0] DIR_RST      = 3'h7;
  localparam logic [2:0] LAT_RST      = 3'h0;
  localparam logic [2:0] ANA_CFG_RST  = 3'h0;
  localparam logic [2:0] ANA_DIGITAL  = 3'h7;
  localparam logic [2:0] PIN_IDLE     = 3'h7;
  localparam logic [7:0] BYTE_RST     = 8'h00;

  typedef enum logic [1:0] {
    HOST_IDLE,
    HOST_WRITE,
    HOST_READ
  } pepsp_host_t;

  typedef struct packed {
    logic [2:0]  pin_s1;
    logic [2:0]  pin_s2;
    logic [7:0]  bus_s1;
    logic [7:0]  bus_s2;
    logic [2:0]  latch;
    logic [2:0]  dir;
    logic        mode;
    logic        input_buffer_full;
    logic        output_buffer_full;
    logic        input_overrun;
    logic [2:0]  ana_cfg;
    logic        irq;
    logic [7:0]  in_buf;
    logic [7:0]  wcap;
    logic [7:0]  out_buf;
    pepsp_host_t host;
    logic        done;
    logic [31:0] rdata;
  } pepsp_state_t;

endpackage
`default_nettype wire

// >>> verilog/pepsp_port.sv
// Three-pin port with direction control and an asynchronous parallel slave port.
//
// Summary of operation
// - Direction one makes the pin an input.
// - Direction zero drives the pin from latch.
// - Latch reads return latch, not pins.
// - Three pins only; upper bits read zero.
// - Analog-selected pins read back as zero.
// - Direction bits still drive pins in analog.
// - Reset leaves all three pins analog.
// - Bit 7 flags a host byte waiting.
// - Bit 6 flags an unread CPU byte.
// - Bit 5 flags host overrun until cleared.
// - Bit 4 selects slave port mode.
// - Bits 2 to 0 are pin directions.
// - Host reads and writes an 8-bit latch.
// - Slave mode makes pins read, write, select.
// - Software sets inputs and digital first.
// - Select and write low start a write.
// - Select and read low start a read.
// - Read low while selected presents data.
// - Write low while selected loads data.
// - Select is active low; high ignores strobes.
//
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`default_nettype none
module pepsp_port
  import pepsp_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_sys_in,
  input  wire logic                rstn_in,
  // Avalon-MM register slave
  input  wire logic [ADDR_W-1:0]   avs_address_in,
  input  wire logic                avs_read_in,
  input  wire logic                avs_write_in,
  input  wire logic [DATA_W-1:0]   avs_writedata_in,
  input  wire logic [3:0]          avs_byteenable_in,
  output logic      [DATA_W-1:0]   avs_readdata_out,
  output logic                     avs_waitrequest_out,
  // Three-pin port
  input  wire logic [2:0]          pin_in,
  output logic      [2:0]          pin_out,
  output logic      [2:0]          pin_oe_out,
  // Byte-wide host data bus
  input  wire logic [7:0]          data_in,
  output logic      [7:0]          data_out,
  output logic                     data_oe_out,
  // Port interrupt flag level
  output logic                     slave_port_irq_flag_out
);

  pepsp_state_t r;
  pepsp_state_t n;

  logic host_sel;
  logic wr_act;
  logic rd_act;
  logic bus_req;
  logic bus_accept;
  logic wr_lane;
  logic pins_digital;
  logic host_wr_done;
  logic host_rd_done;
  logic cpu_data_rd;
  logic cpu_data_wr;

  // Strobes are only looked at after both synchroniser stages.
  assign host_sel     = r.mode & ~r.pin_s2[PIN_CS];
  assign wr_act       = host_sel & ~r.pin_s2[PIN_WR];
  assign rd_act       = host_sel & ~r.pin_s2[PIN_RD];
  assign host_wr_done = (r.host == HOST_WRITE) & ~wr_act;
  assign host_rd_done = (r.host == HOST_READ) & ~rd_act;

  // One wait cycle gives the read mux a registered answer.
  assign bus_req      = avs_read_in | avs_write_in;
  assign bus_accept   = bus_req & r.done;
  assign wr_lane      = avs_write_in & avs_byteenable_in[0];
  assign pins_digital = (r.ana_cfg == ANA_DIGITAL);
  assign cpu_data_rd  = bus_accept & avs_read_in & (avs_address_in == OFF_BYTE_DAT);
  assign cpu_data_wr  = bus_accept & wr_lane & (avs_address_in == OFF_BYTE_DAT);

  always_comb begin
    n = r;
    n.pin_s1 = pin_in;
    n.pin_s2 = r.pin_s1;
    n.bus_s1 = data_in;
    n.bus_s2 = r.bus_s1;

    // Read data is sampled in the wait cycle and held until the accept edge.
    n.done = bus_req & ~r.done;
    if (bus_req & ~r.done & avs_read_in) begin
      n.rdata = '0;
      case (avs_address_in)
        OFF_PIN_DATA: begin
          n.rdata[2:0] = pins_digital ? r.pin_s2 : 3'h0;
        end
        OFF_OUT_LAT: begin
          n.rdata[2:0] = r.latch;
        end
        OFF_DIR_CTL: begin
          n.rdata[CTL_IBF_BIT]  = r.input_buffer_full;
          n.rdata[CTL_OBF_BIT]  = r.output_buffer_full;
          n.rdata[CTL_INPUT_OVERRUN_BIT] = r.input_overrun;
          n.rdata[CTL_MODE_BIT] = r.mode;
          n.rdata[2:0]          = r.dir;
        end
        OFF_BYTE_DAT: begin
          n.rdata[7:0] = r.in_buf;
        end
        OFF_ANA_CFG: begin
          n.rdata[2:0] = r.ana_cfg;
        end
        OFF_IRQ_STAT: begin
          n.rdata[IRQ_FLAG_BIT] = r.irq;
        end
        default: begin
          n.rdata = '0;
        end
      endcase
    end

    // Host side sequencer; a strobe is taken on its first low sample.
    case (r.host)
      HOST_IDLE: begin
        if (wr_act) begin
          n.host = HOST_WRITE;
          n.wcap = r.bus_s2;
        end else if (rd_act) begin
          n.host = HOST_READ;
        end
      end
      HOST_WRITE: begin
        if (wr_act) begin
          n.wcap = r.bus_s2;
        end else begin
          n.host = HOST_IDLE;
        end
      end
      HOST_READ: begin
        if (!rd_act) begin
          n.host = HOST_IDLE;
          n.output_buffer_full  = 1'b0;
        end
      end
      default: begin
        n.host = HOST_IDLE;
      end
    endcase

    // Software writes; clears come first so hardware sets win below.
    if (bus_accept & wr_lane) begin
      case (avs_address_in)
        OFF_PIN_DATA, OFF_OUT_LAT: begin
          n.latch = avs_writedata_in[2:0];
        end
        OFF_DIR_CTL: begin
          n.dir  = avs_writedata_in[2:0];
          n.mode = avs_writedata_in[CTL_MODE_BIT];
          n.input_overrun = r.input_overrun & avs_writedata_in[CTL_INPUT_OVERRUN_BIT];
        end
        OFF_BYTE_DAT: begin
          n.out_buf = avs_writedata_in[7:0];
          n.output_buffer_full     = 1'b1;
        end
        OFF_ANA_CFG: begin
          n.ana_cfg = avs_writedata_in[2:0];
        end
        OFF_IRQ_STAT: begin
          if (avs_writedata_in[IRQ_FLAG_BIT]) begin
            n.irq = 1'b0;
          end
        end
        default: begin
          n.latch = r.latch;
        end
      endcase
    end
    if (cpu_data_rd) begin
      n.input_buffer_full = 1'b0;
    end

    // Host completions set their flags last.
    if (host_wr_done) begin
      n.in_buf = r.wcap;
      n.input_buffer_full    = 1'b1;
      n.irq    = 1'b1;
      if (r.input_buffer_full) begin
        n.input_overrun = 1'b1;
      end
    end
    if (host_rd_done) begin
      n.irq = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r         <= '0;
      // Synchronisers start at the idle high level, so no false strobe follows reset.
      r.pin_s1  <= PIN_IDLE;
      r.pin_s2  <= PIN_IDLE;
      r.latch   <= LAT_RST;
      r.dir     <= DIR_RST;
      r.ana_cfg <= ANA_CFG_RST;
      r.in_buf  <= BYTE_RST;
      r.wcap    <= BYTE_RST;
      r.out_buf <= BYTE_RST;
      r.host    <= HOST_IDLE;
    end else begin
      r <= n;
    end
  end

  // Drivers follow direction even for analog or strobe pins.
  assign pin_out                 = r.latch;
  assign pin_oe_out              = ~r.dir;
  assign data_out                = r.out_buf;
  assign data_oe_out             = rd_act;
  assign avs_readdata_out        = r.rdata;
  assign avs_waitrequest_out     = bus_req & ~r.done;
  assign slave_port_irq_flag_out = r.irq;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rstn_in);

  a_dir_drives_oe: assert property (
    bus_accept && wr_lane && avs_address_in == OFF_DIR_CTL
    |=> pin_oe_out == ~$past(avs_writedata_in[2:0]) && r.dir == $past(avs_writedata_in[2:0])
  ) else $error("direction write did not steer pin drivers");

  a_latch_drives_pin: assert property (
    bus_accept && wr_lane && avs_address_in == OFF_OUT_LAT
    |=> pin_out == $past(avs_writedata_in[2:0])
  ) else $error("latch write did not reach pin outputs");

  a_latch_readback: assert property (
    bus_req && !r.done && avs_read_in && avs_address_in == OFF_OUT_LAT
    |=> avs_readdata_out == {29'h000_0000, $past(r.latch)}
  ) else $error("latch read did not return latch content");

  a_analog_reads_zero: assert property (
    bus_req && !r.done && avs_read_in && avs_address_in == OFF_PIN_DATA && !pins_digital
    |=> avs_readdata_out == 32'h0000_0000
  ) else $error("analog pins did not read as zero");

  a_ctl_readback: assert property (
    bus_req && !r.done && avs_read_in && avs_address_in == OFF_DIR_CTL
    |=> avs_readdata_out[7:0] == {$past(r.input_buffer_full), $past(r.output_buffer_full), $past(r.input_overrun),
                                  $past(r.mode), 1'b0, $past(r.dir)}
  ) else $error("control register read mismatch");

  a_host_write_done: assert property (
    host_wr_done |=> r.input_buffer_full && r.irq && r.in_buf == $past(r.wcap)
  ) else $error("host write completion lost");

  a_host_overrun: assert property (
    host_wr_done && r.input_buffer_full |=> r.input_overrun
  ) else $error("overrun not flagged");

  a_host_read_done: assert property (
    host_rd_done && !cpu_data_wr |=> !r.output_buffer_full && r.irq
  ) else $error("host read did not empty output buffer");

  a_cpu_data_read: assert property (
    cpu_data_rd && !host_wr_done |=> !r.input_buffer_full
  ) else $error("cpu data read did not clear input full");

  a_bus_drive: assert property (
    (r.mode && !pin_in[PIN_CS] && !pin_in[PIN_RD] && $stable(r.mode)) [*3]
    |-> data_oe_out && data_out == r.out_buf
  ) else $error("host read not answered on data bus");

  a_gpio_quiet: assert property (
    !r.mode && $past(!r.mode) |-> r.host == HOST_IDLE && !data_oe_out
  ) else $error("strobes acted outside slave mode");

  a_wait_one: assert property (
    bus_req && avs_waitrequest_out |=> !avs_waitrequest_out
  ) else $error("bus answer later than one cycle");

  a_port_upper_zero: assert property (
    avs_read_in && !avs_waitrequest_out
    && (avs_address_in == OFF_PIN_DATA || avs_address_in == OFF_OUT_LAT)
    |-> avs_readdata_out[31:3] == 29'h000_0000
  ) else $error("unimplemented port bits did not read as zero");

  a_reset_analog: assert property (
    $rose(rstn_in) |-> !pins_digital && r.dir == DIR_RST && !r.mode && !data_oe_out
  ) else $error("pins not analog inputs after reset");

  a_mode_write: assert property (
    bus_accept && wr_lane && avs_address_in == OFF_DIR_CTL
    |=> r.mode == $past(avs_writedata_in[CTL_MODE_BIT])
  ) else $error("mode bit write not taken");

  a_status_read_only: assert property (
    bus_accept && wr_lane && avs_address_in == OFF_DIR_CTL && !host_wr_done && !host_rd_done
    |=> r.input_buffer_full == $past(r.input_buffer_full) && r.output_buffer_full == $past(r.output_buffer_full)
  ) else $error("status flags changed by a control write");

  a_write_strobe_role: assert property (
    r.host == HOST_IDLE && r.mode && r.pin_s2 == 3'h1 |=> r.host == HOST_WRITE
  ) else $error("write strobe pin did not start a host write");

  a_read_strobe_role: assert property (
    r.host == HOST_IDLE && r.mode && r.pin_s2 == 3'h2 |=> r.host == HOST_READ
  ) else $error("read strobe pin did not start a host read");

  a_deselect_ignored: assert property (
    r.host == HOST_IDLE && r.pin_s2[PIN_CS] |=> r.host == HOST_IDLE
  ) else $error("strobes acted while deselected");

  a_oe_after_sync: assert property (
    data_oe_out |-> r.mode && !$past(pin_in[PIN_CS], 2) && !$past(pin_in[PIN_RD], 2)
  ) else $error("data bus driven without synchronised read select");

  a_capture_last: assert property (
    host_wr_done |=> r.in_buf == $past(r.bus_s2, 2)
  ) else $error("host byte not taken from last strobed sample");

  a_cpu_byte_out: assert property (
    cpu_data_wr |=> r.output_buffer_full && data_out == $past(avs_writedata_in[7:0])
  ) else $error("cpu byte write did not load output buffer");

  a_overrun_sticky: assert property (
    r.input_overrun && !(bus_accept && wr_lane && avs_address_in == OFF_DIR_CTL)
    |=> r.input_overrun
  ) else $error("overrun flag cleared without software");

  a_irq_sticky: assert property (
    r.irq && !(bus_accept && wr_lane && avs_address_in == OFF_IRQ_STAT)
    |=> slave_port_irq_flag_out
  ) else $error("interrupt flag cleared without software");

  a_pin_readback: assert property (
    bus_req && !r.done && avs_read_in && avs_address_in == OFF_PIN_DATA && pins_digital
    |=> avs_readdata_out[2:0] == $past(r.pin_s2)
  ) else $error("digital pins did not read back their level");

  c_host_write: cover property (host_wr_done);
  c_host_read: cover property (host_rd_done);
  c_overrun: cover property (host_wr_done && r.input_buffer_full);
  c_cpu_data_read: cover property (cpu_data_rd && r.input_buffer_full);
  c_host_read_data: cover property (data_oe_out && r.output_buffer_full);

endmodule
`default_nettype wire

// >>> tb/pepsp_host.sv
// Host processor model that drives the strobes and data bus of the slave port.
`default_nettype none
module pepsp_host (
  // Clock
  input  wire logic       clk_sys_in,
  // Bus wires as the host sees them
  input  wire logic [7:0] bus_in,
  output logic      [2:0] strb_out,
  output logic      [7:0] data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] hd = 8'h00;
  logic [7:0] tog = 8'h00;
  logic       drv = 1'b0;
  initial strb_out = 3'h7;
  // A released bus changes every cycle, so stale data never looks valid.
  always @(posedge clk_sys_in) tog <= ~tog;
  assign data_out = drv ? hd : tog;
  // One whole access: strobes low six clocks, then high eight clocks.
  task automatic acc(input logic w, input logic cs_n, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk_sys_in);
    hd <= d;
    drv <= w;
    repeat (2) @(posedge clk_sys_in);
    strb_out <= {cs_n, ~w, w};
    repeat (6) @(posedge clk_sys_in);
    q = bus_in;
    strb_out <= 3'h7;
    // Data is held past the write strobe rise for the synchroniser.
    repeat (2) @(posedge clk_sys_in);
    drv <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
  endtask
endmodule
`default_nettype wire

// >>> tb/pepsp_port_test.sv
// Self-checking bench for the three-pin port and its parallel slave port.
`default_nettype none
module pepsp_port_test;
  import pepsp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk_sys_in = 1'b0;
  logic              rstn_in = 1'b0;
  logic [ADDR_W-1:0] adr = '0;
  logic              rd = 1'b0;
  logic              wr = 1'b0;
  logic [31:0]       wd = '0;
  logic [31:0]       rdat;
  logic              wreq;
  logic [2:0]        pout;
  logic [2:0]        poe;
  logic [2:0]        pin;
  logic [2:0]        hstrb;
  logic [7:0]        dout;
  logic [7:0]        hdat;
  logic [7:0]        dbus;
  logic              doe;
  logic              irq;
  logic [7:0]        q;
  int                num_errors = 0;
  int                compares = 0;
  int                cyc = 0;
  assign pin = (poe & pout) | (~poe & hstrb);
  assign dbus = doe ? dout : hdat;
  pepsp_port u_pepsp_port (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(4'hF), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .pin_in(pin), .pin_out(pout), .pin_oe_out(poe),
    .data_in(dbus), .data_out(dout), .data_oe_out(doe),
    .slave_port_irq_flag_out(irq));
  pepsp_host u_pepsp_host (.clk_sys_in(clk_sys_in), .bus_in(dbus),
    .strb_out(hstrb), .data_out(hdat));
  always #50 clk_sys_in = ~clk_sys_in;
  task automatic final_report();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // A hung wait would otherwise stall the run forever.
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk_sys_in);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge clk_sys_in);
    end while (wreq !== 1'b0);
    r = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic bw(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rr(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, '0, r);
    chk($sformatf("reg %h", a), e, r);
  endtask
  task automatic t_reset();
    rr(OFF_DIR_CTL, 32'h0000_0007);
    rr(OFF_ANA_CFG, 32'h0000_0000);
    rr(OFF_PIN_DATA, 32'h0000_0000);
    rr(5'h18, 32'h0000_0000);
    chk("pin_oe", 32'h0000_0000, 32'(poe));
    $display("test reset done");
  endtask
  task automatic t_gpio();
    bw(OFF_OUT_LAT, 32'h0000_00FF);
    rr(OFF_OUT_LAT, 32'h0000_0007);
    bw(OFF_OUT_LAT, 32'h0000_0005);
    bw(OFF_DIR_CTL, 32'h0000_0002);
    @(negedge clk_sys_in);
    chk("pin_oe", 32'h0000_0005, 32'(poe));
    chk("pin_out", 32'h0000_0005, 32'(pout));
    bw(OFF_OUT_LAT, 32'h0000_0000);
    rr(OFF_PIN_DATA, 32'h0000_0000);
    bw(OFF_ANA_CFG, 32'h0000_0007);
    rr(OFF_PIN_DATA, 32'h0000_0002);
    rr(OFF_OUT_LAT, 32'h0000_0000);
    bw(OFF_DIR_CTL, 32'h0000_0007);
    $display("test gpio done");
  endtask
  task automatic t_host_wr();
    bw(OFF_DIR_CTL, 32'h0000_0017);
    u_pepsp_host.acc(1'b1, 1'b0, 8'hA5, q);
    rr(OFF_DIR_CTL, 32'h0000_0097);
    rr(OFF_IRQ_STAT, 32'h0000_0001);
    chk("irq_out", 32'h0000_0001, 32'(irq));
    rr(OFF_BYTE_DAT, 32'h0000_00A5);
    rr(OFF_DIR_CTL, 32'h0000_0017);
    bw(OFF_IRQ_STAT, 32'h0000_0001);
    rr(OFF_IRQ_STAT, 32'h0000_0000);
    chk("irq_out", 32'h0000_0000, 32'(irq));
    $display("test host write done");
  endtask
  task automatic t_overrun();
    u_pepsp_host.acc(1'b1, 1'b0, 8'h11, q);
    u_pepsp_host.acc(1'b1, 1'b0, 8'h22, q);
    rr(OFF_DIR_CTL, 32'h0000_00B7);
    rr(OFF_BYTE_DAT, 32'h0000_0022);
    rr(OFF_DIR_CTL, 32'h0000_0037);
    bw(OFF_DIR_CTL, 32'h0000_0017);
    rr(OFF_DIR_CTL, 32'h0000_0017);
    $display("test overrun done");
  endtask
  task automatic t_host_rd();
    bw(OFF_IRQ_STAT, 32'h0000_0001);
    bw(OFF_BYTE_DAT, 32'h0000_003C);
    rr(OFF_DIR_CTL, 32'h0000_0057);
    u_pepsp_host.acc(1'b0, 1'b0, 8'h00, q);
    chk("host byte", 32'h0000_003C, 32'(q));
    chk("data_oe", 32'h0000_0000, 32'(doe));
    rr(OFF_DIR_CTL, 32'h0000_0017);
    rr(OFF_IRQ_STAT, 32'h0000_0001);
    bw(OFF_IRQ_STAT, 32'h0000_0001);
    $display("test host read done");
  endtask
  task automatic t_ignored();
    u_pepsp_host.acc(1'b1, 1'b1, 8'h5A, q);
    rr(OFF_DIR_CTL, 32'h0000_0017);
    rr(OFF_IRQ_STAT, 32'h0000_0000);
    bw(OFF_DIR_CTL, 32'h0000_0007);
    u_pepsp_host.acc(1'b1, 1'b0, 8'h5A, q);
    rr(OFF_DIR_CTL, 32'h0000_0007);
    rr(OFF_IRQ_STAT, 32'h0000_0000);
    $display("test ignored done");
  endtask
  initial begin
    repeat (16) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    t_reset();
    t_gpio();
    t_host_wr();
    t_overrun();
    t_host_rd();
    t_ignored();
    final_report();
  end
endmodule
`default_nettype wire
